// file: core/hbp_pkg.sv
// constants and types shared by the host byte port pin logic
// assumes a single system clock and a synchronous active-low reset
package hbp_pkg;
   // register-select codes carried by reg_select_1/reg_select_0
   localparam logic [1:0] SEL_CTRL = 2'h0; // port_control_reg
   localparam logic [1:0] SEL_DATA_INC = 2'h1; // data latches, auto increment
   localparam logic [1:0] SEL_ADDR = 2'h2; // port_address_pointer
   localparam logic [1:0] SEL_DATA = 2'h3; // data latches, pointer kept
   // packed pin vector layout, msb first
   localparam int unsigned PIN_W = 16;
   localparam int unsigned PIN_AS = 15; // addr_strobe_n
   localparam int unsigned PIN_CS = 14; // port_select_n
   localparam int unsigned PIN_DSA = 13; // data_strobe_a_n
   localparam int unsigned PIN_DSB = 12; // data_strobe_b_n
   localparam int unsigned PIN_RNW = 11; // read_not_write
   localparam int unsigned PIN_RS1 = 10; // reg_select_1
   localparam int unsigned PIN_RS0 = 9; // reg_select_0
   localparam int unsigned PIN_BIL = 8; // byte_position_sel
   // idle pin picture: all strobes high, so nothing looks active at reset
   localparam logic [15:0] PIN_IDLE = 16'hF000;
   // reset values
   localparam logic IRQ_RST = 1'h1; // host_irq driven high in reset
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // event word: {rnw, sel[1:0], data[15:0]}
   localparam int unsigned EVT_W = 19;
   // byte sequencing inside one word access
   typedef enum logic [0:0] {
      SEQ_FIRST = 1'b0, // expecting the first byte
      SEQ_SECOND = 1'b1 // first byte seen, waiting for the second
   } seq_e;
endpackage : hbp_pkg

// file: core/two_entry_buf.sv
// two-entry valid/ready buffer with registered outputs
// assumes both sides run on clk_sys; in_ready stalls the source
`timescale 1ns/1ns
`default_nettype none
module two_entry_buf #(
   parameter int unsigned WIDTH = 19
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] d0_r; // head entry, drives out_data
   logic [WIDTH-1:0] d1_r; // second entry
   logic v0_r; // head holds a word
   logic v1_r; // second entry holds a word
   logic push;
   logic pop;

   // full only when both slots are taken; back-pressure is honest
   assign in_ready = ~v1_r;
   assign out_valid = v0_r;
   assign out_data = d0_r;
   assign push = in_valid & ~v1_r;
   assign pop = v0_r & out_ready;

   // slot bookkeeping; the head always leaves first
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         v0_r <= 1'b0;
         v1_r <= 1'b0;
         d0_r <= '0;
         d1_r <= '0;
      end else if (pop) begin
         // head leaves; second entry or the new word moves up
         d0_r <= v1_r ? d1_r : in_data;
         v0_r <= v1_r | push;
         v1_r <= v1_r & push;
         if (v1_r && push) begin
            d1_r <= in_data;
         end
      end else if (push) begin
         if (!v0_r) begin
            d0_r <= in_data;
            v0_r <= 1'b1;
         end else begin
            d1_r <= in_data;
            v1_r <= 1'b1;
         end
      end
   end
endmodule : two_entry_buf
`default_nettype wire

// file: core/host_byte_port_pin_logic.sv
// pin-level logic of an 8-bit host byte port
// assumes host pins are asynchronous to clk_sys and are synchronised here;
// the dsp side supplies read words and control bits on clk_sys
//
// How it works
// R01: address strobe fall latches select, direction, position
// R02: host asserts address strobe before last strobe
// R03: host may tie address strobe high
// R04: without address strobe, last select/strobe edge latches
// R05: position low first byte, high second byte
// R06: byte order bit picks most significant byte
// R07: register select picks pointer, data or control
// R08: host holds port select low during access
// R09: port select edge samples when strobe already low
// R10: data bus released whenever strobe condition inactive
// R11: data strobes govern the actual byte movement
// R12: host wires read/write strobes or single strobe
// R13: direction always from read_not_write input
// R14: data strobes combined by exclusive-nor
// R15: host_irq follows the control interrupt bit
// R16: host_irq driven high during reset
// R17: codes 00 ctrl, 01 inc data, 10 pointer, 11 data
// R18: host drives read_not_write high to read
// R19: host never breaks first/second byte sequence
`timescale 1ns/1ns
`default_nettype none
module host_byte_port_pin_logic
   import hbp_pkg::*;
#(
   parameter int unsigned WORD_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   // host pins
   input wire logic addr_strobe_n,
   input wire logic port_select_n,
   input wire logic data_strobe_a_n,
   input wire logic data_strobe_b_n,
   input wire logic read_not_write,
   input wire logic reg_select_0,
   input wire logic reg_select_1,
   input wire logic byte_position_sel,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   output logic host_irq,
   // dsp-side control bits and read word
   input wire logic irq_ctrl_bit,
   input wire logic byte_order_bit,
   input wire logic [WORD_W-1:0] rd_word,
   // completed word accesses towards the dsp side
   output logic evt_valid,
   input wire logic evt_ready,
   output logic evt_rnw,
   output logic [1:0] evt_sel,
   output logic [WORD_W-1:0] evt_data,
   // sticky error flags, cleared only by reset
   output logic seq_error,
   output logic evt_overflow
);
   logic [PIN_W-1:0] pins; // raw host pins, packed
   logic [PIN_W-1:0] meta_r; // first synchroniser stage
   logic [PIN_W-1:0] sync_r; // second stage, the only one logic reads
   logic as_s, cs_s, dsa_s, dsb_s, rnw_s, bil_s;
   logic [1:0] sel_s;
   logic [7:0] data_s;
   logic strobe_on; // combined select/strobe condition
   logic as_prev_r; // address strobe one cycle back
   logic strobe_prev_r; // strobe condition one cycle back
   logic as_fall, strobe_rise, strobe_fall;
   logic as_seen_r; // address strobe used in this access
   logic ctl_rnw_r; // latched direction
   logic [1:0] ctl_sel_r; // latched register select
   logic ctl_bil_r; // latched byte position
   seq_e seq_r; // byte sequencing state
   logic [7:0] first_byte_r; // first written byte of a word
   logic word_done; // second byte just finished
   logic pend_r; // word waiting to enter the buffer
   logic pend_rnw_r;
   logic [1:0] pend_sel_r;
   logic [WORD_W-1:0] pend_data_r;
   logic buf_in_ready; // buffer can take the pending word
   logic [7:0] data_out_r;
   logic data_oe_r;
   logic irq_r;
   logic seq_error_r;
   logic overflow_r;
   logic [EVT_W-1:0] evt_word;

   // pick the byte for a read: first or second, arranged by byte order
   function automatic logic [7:0] byte_pick(input logic [15:0] w,
                                            input logic second,
                                            input logic first_msb);
      byte_pick = (second ^ first_msb) ? w[15:8] : w[7:0];
   endfunction : byte_pick

   // put two written bytes together as one word
   function automatic logic [15:0] byte_merge(input logic [7:0] first,
                                              input logic [7:0] second,
                                              input logic first_msb);
      byte_merge = first_msb ? {first, second} : {second, first};
   endfunction : byte_merge

   assign pins = {addr_strobe_n, port_select_n, data_strobe_a_n,
                  data_strobe_b_n, read_not_write, reg_select_1,
                  reg_select_0, byte_position_sel, host_data_in};

   // two-stage synchroniser for every host pin
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta_r <= PIN_IDLE;
         sync_r <= PIN_IDLE;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end

   // unpack the synchronised picture
   assign as_s = sync_r[PIN_AS];
   assign cs_s = sync_r[PIN_CS];
   assign dsa_s = sync_r[PIN_DSA];
   assign dsb_s = sync_r[PIN_DSB];
   assign rnw_s = sync_r[PIN_RNW];
   assign sel_s = {sync_r[PIN_RS1], sync_r[PIN_RS0]};
   assign bil_s = sync_r[PIN_BIL];
   assign data_s = sync_r[7:0];

   // strobes meet in an xnor: both low or both high is not enabled, so
   // an active-high strobe works with the other input tied low
   assign strobe_on = ~cs_s & (dsa_s ^ dsb_s); // R14 R11

   // edge history of the address strobe and combined strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         as_prev_r <= 1'b1;
         strobe_prev_r <= 1'b0;
      end else begin
         as_prev_r <= as_s;
         strobe_prev_r <= strobe_on;
      end
   end

   assign as_fall = as_prev_r & ~as_s;
   // whichever of select or strobes comes last makes this rise
   assign strobe_rise = strobe_on & ~strobe_prev_r; // R04 R09
   assign strobe_fall = ~strobe_on & strobe_prev_r;

   // control latch: address strobe fall wins; otherwise the strobe rise
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         as_seen_r <= 1'b0;
         ctl_rnw_r <= 1'b1;
         ctl_sel_r <= SEL_CTRL;
         ctl_bil_r <= 1'b0;
      end else if (as_fall) begin
         as_seen_r <= 1'b1;
         ctl_rnw_r <= rnw_s; // R01 R13
         ctl_sel_r <= sel_s; // R01 R07
         ctl_bil_r <= bil_s; // R01 R05
      end else if (strobe_rise && !as_seen_r) begin
         ctl_rnw_r <= rnw_s; // R04 R09 R13
         ctl_sel_r <= sel_s; // R04 R09 R07
         ctl_bil_r <= bil_s; // R04 R09 R05
      end else if (strobe_fall) begin
         // the next access needs a fresh address strobe
         as_seen_r <= 1'b0;
      end
   end

   // byte sequencing; a second byte without a first is flagged, not used
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         seq_r <= SEQ_FIRST;
         first_byte_r <= BYTE_RST;
         seq_error_r <= 1'b0;
      end else if (strobe_fall) begin
         case (seq_r)
            SEQ_FIRST: begin
               if (!ctl_bil_r) begin
                  first_byte_r <= data_s; // R05 R11
                  seq_r <= SEQ_SECOND;
               end else begin
                  seq_error_r <= 1'b1; // R19
               end
            end
            SEQ_SECOND: begin
               if (ctl_bil_r) begin
                  seq_r <= SEQ_FIRST;
               end else begin
                  // broken sequence: restart on this byte
                  first_byte_r <= data_s;
                  seq_error_r <= 1'b1; // R19
               end
            end
            default: begin
               seq_r <= SEQ_FIRST;
            end
         endcase
      end
   end

   assign word_done = strobe_fall & ctl_bil_r & (seq_r == SEQ_SECOND);

   // pending word; if the buffer stalls too long a new word is dropped
   // and flagged as overflow rather than corrupting the held one
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
         pend_rnw_r <= 1'b1;
         pend_sel_r <= SEL_CTRL;
         pend_data_r <= WORD_RST;
         overflow_r <= 1'b0;
      end else if (word_done && (!pend_r || buf_in_ready)) begin
         pend_r <= 1'b1;
         pend_rnw_r <= ctl_rnw_r; // R13
         pend_sel_r <= ctl_sel_r; // R07 R17
         pend_data_r <= ctl_rnw_r ? rd_word
                        : byte_merge(first_byte_r, data_s,
                                     byte_order_bit); // R06
      end else if (word_done) begin
         overflow_r <= 1'b1;
      end else if (pend_r && buf_in_ready) begin
         pend_r <= 1'b0;
      end
   end

   assign evt_word = {pend_rnw_r, pend_sel_r, pend_data_r};

   // two-entry buffer plus the pending word, so a stalled dsp side loses no word until three are held
   two_entry_buf #(
      .WIDTH(EVT_W)
   ) u_evt_buf (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(pend_r),
      .in_ready(buf_in_ready),
      .in_data(evt_word),
      .out_valid(evt_valid),
      .out_ready(evt_ready),
      .out_data({evt_rnw, evt_sel, evt_data})
   );

   // read drive: only after the control latch has settled, and only
   // while the strobe condition holds, so the bus floats otherwise
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         data_oe_r <= 1'b0;
         data_out_r <= BYTE_RST;
      end else begin
         data_oe_r <= strobe_on & strobe_prev_r & ctl_rnw_r; // R10 R13
         data_out_r <= byte_pick(rd_word, ctl_bil_r,
                                 byte_order_bit); // R06 R11
      end
   end

   // host interrupt pin; forced high while reset is held
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_r <= IRQ_RST; // R16
      end else begin
         irq_r <= irq_ctrl_bit; // R15
      end
   end

   assign host_data_out = data_out_r;
   assign host_data_oe = data_oe_r;
   assign host_irq = irq_r;
   assign seq_error = seq_error_r;
   assign evt_overflow = overflow_r;

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence s_read_open;
      (strobe_rise && !as_seen_r && !as_fall && rnw_s) ##1 strobe_on;
   endsequence
   sequence s_both_low;
      (!cs_s && !dsa_s && !dsb_s) [*2];
   endsequence
   property p_as_latch;
      as_fall |=> (ctl_sel_r == $past(sel_s)) && (ctl_bil_r == $past(bil_s));
   endproperty
   a_as_latch: assert property (p_as_latch) // R01
      else $error("control not latched on address strobe fall");
   property p_strobe_latch;
      (strobe_rise && !as_seen_r && !as_fall) |=>
         (ctl_rnw_r == $past(rnw_s)) && (ctl_sel_r == $past(sel_s));
   endproperty
   a_strobe_latch: assert property (p_strobe_latch) // R04
      else $error("control not latched on last strobe edge");
   property p_bus_release;
      !strobe_on |=> !host_data_oe;
   endproperty
   a_bus_release: assert property (p_bus_release) // R10
      else $error("data bus driven with strobe inactive");
   property p_read_drive;
      s_read_open |=> host_data_oe;
   endproperty
   a_read_drive: assert property (p_read_drive) // R11
      else $error("read byte not driven during strobe");
   property p_dir_only;
      host_data_oe |-> $past(ctl_rnw_r);
   endproperty
   a_dir_only: assert property (p_dir_only) // R13
      else $error("bus driven on a write access");
   property p_xnor_idle;
      s_both_low |=> !host_data_oe;
   endproperty
   a_xnor_idle: assert property (p_xnor_idle) // R14
      else $error("both strobes low treated as enabled");
   property p_byte_order;
      (word_done && !ctl_rnw_r && (!pend_r || buf_in_ready)) |=>
         pend_data_r == byte_merge($past(first_byte_r), $past(data_s),
                                   $past(byte_order_bit));
   endproperty
   a_byte_order: assert property (p_byte_order) // R06
      else $error("written word assembled in wrong byte order");
   property p_sel_kept;
      (word_done && (!pend_r || buf_in_ready)) |=>
         pend_r && (pend_sel_r == $past(ctl_sel_r));
   endproperty
   a_sel_kept: assert property (p_sel_kept) // R17
      else $error("register select lost on completed word");
   property p_irq_follow;
      $past(rst_b) |-> host_irq == $past(irq_ctrl_bit);
   endproperty
   a_irq_follow: assert property (p_irq_follow) // R15
      else $error("host_irq does not follow the control bit");
   property p_irq_reset;
      @(posedge clk_sys) disable iff (1'b0) !rst_b |=> host_irq;
   endproperty
   a_irq_reset: assert property (p_irq_reset) // R16
      else $error("host_irq not high in reset");
endmodule : host_byte_port_pin_logic
`default_nettype wire

// file: sim/host_bus_model.sv
// behavioural host processor driving the byte port pins
// assumes clk_sys only paces it; all pins change at falling edges
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
   input wire logic clk_sys,
   input wire logic [7:0] host_data_bus,
   output logic addr_strobe_n,
   output logic port_select_n,
   output logic data_strobe_a_n,
   output logic data_strobe_b_n,
   output logic read_not_write,
   output logic reg_select_1,
   output logic reg_select_0,
   output logic byte_position_sel,
   output logic [7:0] drv_data,
   output logic drv_en
);
   // idle bus picture: nothing selected, address strobe unused
   initial begin
      addr_strobe_n = 1'b1;
      port_select_n = 1'b1;
      {data_strobe_a_n, data_strobe_b_n} = 2'h3;
      {read_not_write, reg_select_1, reg_select_0} = 3'h4;
      byte_position_sel = 1'b0;
      drv_data = 8'h00;
      drv_en = 1'b0;
   end

   // one byte access; mode 0/1 strobe a/b low, 2 strobe a high with b low,
   // 3 strobe already on when select falls last
   task automatic byte_cycle(input logic [1:0] mode, input logic rnw_i,
      input logic [1:0] sel_i, input logic bil_i, input logic [7:0] d,
      input logic as_on, output logic [7:0] rd);
      logic [1:0] act;
      logic [1:0] idl;
      act = (mode == 2'h0 || mode == 2'h3) ? 2'h1 : 2'h2;
      idl = (mode == 2'h2) ? 2'h0 : 2'h3;
      @(negedge clk_sys);
      {data_strobe_a_n, data_strobe_b_n} = idl;
      {read_not_write, reg_select_1, reg_select_0} = {rnw_i, sel_i};
      byte_position_sel = bil_i;
      drv_data = d;
      drv_en = !rnw_i;
      if (as_on) begin
         // address phase first, then the control lines are scrambled
         addr_strobe_n = 1'b0;
         repeat (4) @(negedge clk_sys);
         addr_strobe_n = 1'b1;
         {read_not_write, reg_select_1, reg_select_0} = ~{rnw_i, sel_i};
         byte_position_sel = ~bil_i;
      end
      repeat (2) @(negedge clk_sys);
      if (mode == 2'h3) begin
         {data_strobe_a_n, data_strobe_b_n} = act;
         repeat (4) @(negedge clk_sys);
         port_select_n = 1'b0;
      end else begin
         port_select_n = 1'b0;
         repeat (4) @(negedge clk_sys);
         {data_strobe_a_n, data_strobe_b_n} = act;
      end
      repeat (8) @(negedge clk_sys);
      rd = host_data_bus;
      // end of strobe; write data held a few cycles past it
      if (mode == 2'h3) port_select_n = 1'b1;
      else {data_strobe_a_n, data_strobe_b_n} = idl;
      repeat (4) @(negedge clk_sys);
      drv_en = 1'b0;
      port_select_n = 1'b1;
      {data_strobe_a_n, data_strobe_b_n} = idl;
      repeat (4) @(negedge clk_sys);
   endtask : byte_cycle
endmodule : host_bus_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the host byte port pin logic
// assumes the host model paces pins; the bench plays the dsp side
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import hbp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic as_n, cs_n, dsa_n, dsb_n, rnw, rs1, rs0, bil;
   logic [7:0] drv_data, host_data_out, bus_last;
   logic [7:0] host_data_bus; // resolved pin level
   logic drv_en, host_data_oe, host_irq;
   logic irq_ctrl_bit = 1'b0;
   logic byte_order_bit = 1'b0;
   logic [15:0] rd_word = 16'h0000;
   logic evt_valid, evt_rnw, seq_error, evt_overflow;
   logic evt_ready = 1'b0;
   logic [1:0] evt_sel;
   logic [15:0] evt_data;
   int err_total = 0;
   int check_count = 0;

   // clock, 4 ns period
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   // released bus shows the inverse of its last level, no pull
   always @(negedge clk_sys) bus_last <= host_data_bus;
   assign host_data_bus = host_data_oe ? host_data_out :
                          drv_en ? drv_data : ~bus_last;

   host_bus_model i_host (.clk_sys(clk_sys), .host_data_bus(host_data_bus),
      .addr_strobe_n(as_n), .port_select_n(cs_n), .data_strobe_a_n(dsa_n),
      .data_strobe_b_n(dsb_n), .read_not_write(rnw), .reg_select_1(rs1),
      .reg_select_0(rs0), .byte_position_sel(bil), .drv_data(drv_data),
      .drv_en(drv_en));

   host_byte_port_pin_logic i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .addr_strobe_n(as_n), .port_select_n(cs_n), .data_strobe_a_n(dsa_n),
      .data_strobe_b_n(dsb_n), .read_not_write(rnw), .reg_select_0(rs0),
      .reg_select_1(rs1), .byte_position_sel(bil),
      .host_data_in(host_data_bus), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe), .host_irq(host_irq),
      .irq_ctrl_bit(irq_ctrl_bit), .byte_order_bit(byte_order_bit),
      .rd_word(rd_word), .evt_valid(evt_valid), .evt_ready(evt_ready),
      .evt_rnw(evt_rnw), .evt_sel(evt_sel), .evt_data(evt_data),
      .seq_error(seq_error), .evt_overflow(evt_overflow));

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   // single-bit result
   task automatic chk_flag(input string what, input logic exp,
      input logic got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s exp %b got %b", what, exp, got);
      end
   endtask : chk_flag

   // byte or word result
   task automatic chk_word(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask : chk_word

   // pop one event under a bounded wait and compare it
   task automatic pop_check(input logic r, input logic [1:0] s,
      input logic [15:0] w);
      int n;
      @(negedge clk_sys);
      evt_ready = 1'b1;
      for (n = 0; n < 40 && evt_valid !== 1'b1; n++) @(negedge clk_sys);
      if (n == 40) begin
         err_total++;
         final_report();
      end
      chk_flag("evt_rnw", r, evt_rnw);
      chk_word("evt_sel", {14'h0, s}, {14'h0, evt_sel});
      chk_word("evt_data", w, evt_data);
      @(negedge clk_sys);
      evt_ready = 1'b0;
   endtask : pop_check

   // one two-byte word access; reads compare each byte on the bus
   task automatic xfer(input logic [1:0] mode, input logic r,
      input logic [1:0] s, input logic bo, input logic [15:0] w,
      input logic as_on, input logic pop);
      logic [7:0] rd;
      logic [7:0] fb; // byte that travels first
      logic [7:0] sb; // byte that travels second
      // byte order set: the first byte is the upper half of the word
      fb = bo ? w[15:8] : w[7:0];
      sb = bo ? w[7:0] : w[15:8];
      byte_order_bit = bo;
      rd_word = w;
      // first byte then second byte, never broken in between
      i_host.byte_cycle(mode, r, s, 1'b0, fb, as_on, rd);
      if (r) chk_word("rd first", {8'h00, fb}, {8'h00, rd});
      chk_flag("oe released", 1'b0, host_data_oe);
      i_host.byte_cycle(mode, r, s, 1'b1, sb, as_on, rd);
      if (r) chk_word("rd second", {8'h00, sb}, {8'h00, rd});
      if (pop) pop_check(r, s, w);
   endtask : xfer

   // irq pin high in reset, then follows the control bit
   task automatic t_reset();
      repeat (10) @(negedge clk_sys);
      chk_flag("irq in reset", IRQ_RST, host_irq);
      chk_flag("oe in reset", 1'b0, host_data_oe);
      repeat (10) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk_flag("irq low", 1'b0, host_irq);
      irq_ctrl_bit = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk_flag("irq high", 1'b1, host_irq);
   endtask : t_reset

   // every strobe wiring and every select code, writes and reads
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         xfer(m[1:0], 1'b0, m[1:0], m[0], 16'hA5C3 ^ 16'(m * 16'h1111), 1'b0,
              1'b1);
         xfer(m[1:0], 1'b1, ~m[1:0], ~m[0], 16'h3C96 + 16'(m), 1'b0,
              1'b1);
      end
   endtask : t_modes

   // control taken at the address strobe fall, then scrambled
   task automatic t_addr_strobe();
      xfer(2'h0, 1'b0, SEL_ADDR, 1'b1, 16'h7E81, 1'b1, 1'b1);
      xfer(2'h1, 1'b1, SEL_DATA, 1'b0, 16'hB24D, 1'b1, 1'b1);
   endtask : t_addr_strobe

   // stalled consumer: three words held, fourth dropped
   task automatic t_stall();
      for (int i = 0; i < 4; i++) begin
         // three held words must not raise the flag yet
         chk_flag("no overflow", 1'b0, evt_overflow);
         xfer(2'h0, 1'b0, SEL_DATA_INC, 1'b1, 16'h1200 + 16'(i), 1'b0,
              1'b0);
      end
      chk_flag("overflow", 1'b1, evt_overflow);
      for (int i = 0; i < 3; i++) begin
         pop_check(1'b0, SEL_DATA_INC, 16'h1200 + 16'(i));
      end
      repeat (3) @(negedge clk_sys);
      chk_flag("drained", 1'b0, evt_valid);
   endtask : t_stall

   // a lone second byte is refused and flagged
   task automatic t_seq_err();
      logic [7:0] rd;
      // all earlier accesses kept the byte order, so the flag is clear
      chk_flag("seq clean", 1'b0, seq_error);
      i_host.byte_cycle(2'h0, 1'b0, SEL_DATA, 1'b1, 8'h5A, 1'b0, rd);
      repeat (6) @(negedge clk_sys);
      chk_flag("seq_error", 1'b1, seq_error);
      chk_flag("no event", 1'b0, evt_valid);
   endtask : t_seq_err

   // watchdog against a hang anywhere
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      final_report();
   end

   initial begin
      t_reset();
      t_modes();
      t_addr_strobe();
      t_stall();
      t_seq_err();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
